// File: logic/ifa_top.sv
// Transmit and receive byte queues, fill levels and own-address match.
// Assumes a same-clock register port and a byte engine on the link clock.
`timescale 1ns/1ps

// ************************************************
// Dual-clock queue with gray pointers
// ************************************************
module ifa_async_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned AW = 4
) (
  input wire logic i_wclk,
  input wire logic i_wrst_n,
  input wire logic i_wr,
  input wire logic [W-1:0] i_wdata,
  output logic o_full,
  output logic [AW:0] o_wcount,
  output logic [W-1:0] o_whead,
  input wire logic i_rclk,
  input wire logic i_rrst_n,
  input wire logic i_rd,
  input wire logic i_flush,
  output logic o_empty,
  output logic [AW:0] o_rcount,
  output logic [W-1:0] o_rhead
);
  localparam logic [AW:0] DEPTH = (AW+1)'(2 ** AW);
  localparam logic [AW:0] ONE = (AW+1)'(1);

  function automatic logic [AW:0] b2g(input logic [AW:0] b);
    b2g = b ^ (b >> 1);
  endfunction

  function automatic logic [AW:0] g2b(input logic [AW:0] g);
    logic [AW:0] b;
    b = '0;
    for (int i = AW; i >= 0; i--) begin
      b[i] = (i == AW) ? g[i] : (b[i+1] ^ g[i]);
    end
    g2b = b;
  endfunction

  // Storage has no reset so the last head byte survives a reset
  logic [W-1:0] mem_reg [2**AW];
  logic [AW:0] wbin_reg;
  logic [AW:0] wgray_reg;
  logic [AW:0] rgray_w1_reg;
  logic [AW:0] rgray_w2_reg;
  logic [AW:0] rbin_reg;
  logic [AW:0] rgray_reg;
  logic [AW:0] wgray_r1_reg;
  logic [AW:0] wgray_r2_reg;
  logic [AW:0] rbin_w;
  logic [AW:0] wbin_r;
  logic [AW:0] wbin_next;
  logic [AW:0] rbin_next;
  logic wr_ok;
  logic rd_ok;
  logic head_ok_reg;

  assign rbin_w = g2b(rgray_w2_reg);
  assign wbin_r = g2b(wgray_r2_reg);
  assign o_wcount = wbin_reg - rbin_w;
  assign o_full = (o_wcount == DEPTH);
  assign wr_ok = i_wr && !o_full;
  assign wbin_next = wr_ok ? wbin_reg + ONE : wbin_reg;
  assign o_rcount = wbin_r - rbin_reg;
  // Empty follows the head copy, so a stale head is never offered
  assign o_empty = !head_ok_reg;
  // flush drains one entry a cycle, keeping gray steps single-bit
  assign rd_ok = (i_rd || i_flush) && !o_empty;
  assign rbin_next = rd_ok ? rbin_reg + ONE : rbin_reg;

  always_ff @(posedge i_wclk) begin
    if (wr_ok) begin
      mem_reg[wbin_reg[AW-1:0]] <= i_wdata;
    end
  end

  always_ff @(posedge i_wclk or negedge i_wrst_n) begin
    if (!i_wrst_n) begin
      wbin_reg <= '0;
      wgray_reg <= '0;
      rgray_w1_reg <= '0;
      rgray_w2_reg <= '0;
    end else begin
      wbin_reg <= wbin_next;
      wgray_reg <= b2g(wbin_next);
      rgray_w1_reg <= rgray_reg;
      rgray_w2_reg <= rgray_w1_reg;
    end
  end

  // head copies hold while empty, also across reset
  always_ff @(posedge i_wclk) begin
    if (o_wcount != '0) begin
      o_whead <= mem_reg[rbin_w[AW-1:0]];
    end
  end

  always_ff @(posedge i_rclk or negedge i_rrst_n) begin
    if (!i_rrst_n) begin
      head_ok_reg <= 1'b0;
      rbin_reg <= '0;
      rgray_reg <= '0;
      wgray_r1_reg <= '0;
      wgray_r2_reg <= '0;
    end else begin
      head_ok_reg <= (rbin_next != wbin_r);
      rbin_reg <= rbin_next;
      rgray_reg <= b2g(rbin_next);
      wgray_r1_reg <= wgray_reg;
      wgray_r2_reg <= wgray_r1_reg;
    end
  end

  always_ff @(posedge i_rclk) begin
    if (rbin_next != wbin_r) begin
      o_rhead <= mem_reg[rbin_next[AW-1:0]];
    end
  end
endmodule // ifa_async_fifo

// ************************************************
// Top: register port, queues, address match
// ************************************************
module ifa_top #(
  parameter bit WIDE_ADDRESS_OPTION = 1'b1
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_link_clk,
  input wire logic [8:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [31:0] i_reg_wdata,
  output logic [31:0] o_reg_rdata,
  input wire logic i_master_slave_select,
  input wire logic i_tx_queue_reset,
  output logic o_tx_empty,
  output logic o_tx_full,
  output logic o_rx_empty,
  output logic o_rx_full,
  output logic o_rx_level_hit,
  output logic o_link_tx_valid,
  output logic [7:0] o_link_tx_data,
  output logic o_link_tx_start,
  output logic o_link_tx_repeat_start,
  output logic o_link_tx_stop,
  output logic o_link_rx_count_valid,
  input wire logic i_link_master_rx,
  input wire logic i_link_tx_pop,
  input wire logic i_link_rx_push,
  input wire logic [7:0] i_link_rx_data,
  output logic o_link_throttle,
  output logic o_link_gen_start,
  output logic o_link_gen_stop,
  input wire logic i_link_addr_valid,
  input wire logic i_link_addr_second,
  input wire logic [7:0] i_link_addr_byte,
  output logic o_link_addr_ack
);
  localparam int unsigned AW = ifa_pkg::QUEUE_AW;
  localparam logic [AW:0] ONE = (AW+1)'(1);

  // ************************************************
  // Reset release in both domains
  // ************************************************
  logic rst_c1_reg;
  logic rstn_core;
  logic rst_l1_reg;
  logic rstn_link;

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_c1_reg <= 1'b0;
      rstn_core <= 1'b0;
    end else begin
      rst_c1_reg <= 1'b1;
      rstn_core <= rst_c1_reg;
    end
  end

  always_ff @(posedge i_link_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_l1_reg <= 1'b0;
      rstn_link <= 1'b0;
    end else begin
      rst_l1_reg <= 1'b1;
      rstn_link <= rst_l1_reg;
    end
  end

  // ************************************************
  // Register state
  // ************************************************
  logic [6:0] own_addr_reg;
  logic [2:0] upper_addr_reg;
  logic [3:0] rx_threshold_reg;
  logic [AW:0] tx_wcount;
  logic [AW:0] rx_wcount;
  logic [AW:0] rx_rcount;
  logic [9:0] tx_whead;
  logic [9:0] tx_rhead;
  logic [7:0] rx_rhead;
  logic tx_wr;
  logic rx_pop;
  logic tx_full;
  logic tx_empty_link;
  logic rx_full_link;
  logic rx_empty;
  logic [3:0] tx_fill;
  logic [3:0] rx_fill;
  logic [31:0] rdata_next;

  // keyhole write queues byte and flags
  assign tx_wr = i_reg_wr && (i_reg_addr == ifa_pkg::OFS_TX_KEYHOLE) && !i_tx_queue_reset;
  // keyhole read pops only when something is there
  assign rx_pop = i_reg_rd && (i_reg_addr == ifa_pkg::OFS_RX_KEYHOLE) && !rx_empty;
  // level field is count minus one, zero when empty
  assign tx_fill = (tx_wcount == '0) ? ifa_pkg::FILL_RESET : 4'(tx_wcount - ONE);
  assign rx_fill = (rx_rcount == '0) ? ifa_pkg::FILL_RESET : 4'(rx_rcount - ONE);
  assign o_tx_empty = (tx_wcount == '0);
  assign o_tx_full = tx_full;
  assign o_rx_empty = rx_empty;
  assign o_rx_level_hit = !rx_empty && (rx_fill == rx_threshold_reg);

  always_ff @(posedge i_core_clk or negedge rstn_core) begin
    if (!rstn_core) begin
      own_addr_reg <= ifa_pkg::OWN_RESET;
      rx_threshold_reg <= ifa_pkg::FILL_RESET;
    end else if (i_reg_wr) begin
      if (i_reg_addr == ifa_pkg::OFS_OWN_ADDR) begin
        own_addr_reg <= i_reg_wdata[ifa_pkg::OWN_MSB:ifa_pkg::OWN_LSB];
      end
      if (i_reg_addr == ifa_pkg::OFS_RX_THRESHOLD) begin
        rx_threshold_reg <= i_reg_wdata[ifa_pkg::FILL_W-1:0];
      end
    end
  end

  // upper register built only with the wide option
  generate
    if (WIDE_ADDRESS_OPTION) begin : g_upper
      always_ff @(posedge i_core_clk or negedge rstn_core) begin
        if (!rstn_core) begin
          upper_addr_reg <= ifa_pkg::UPPER_RESET;
        end else if (i_reg_wr && (i_reg_addr == ifa_pkg::OFS_UPPER_ADDR)) begin
          upper_addr_reg <= i_reg_wdata[ifa_pkg::UPPER_W-1:0];
        end
      end
    end else begin : g_no_upper
      assign upper_addr_reg = ifa_pkg::UPPER_RESET;
    end
  endgenerate

  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (i_reg_addr)
      // head byte, no pop; flags hidden
      ifa_pkg::OFS_TX_KEYHOLE: rdata_next[7:0] = tx_whead[7:0];
      ifa_pkg::OFS_RX_KEYHOLE: rdata_next[7:0] = rx_rhead;
      ifa_pkg::OFS_OWN_ADDR: rdata_next[ifa_pkg::OWN_MSB:ifa_pkg::OWN_LSB] = own_addr_reg;
      ifa_pkg::OFS_TX_FILL: rdata_next[3:0] = tx_fill;
      ifa_pkg::OFS_RX_FILL: rdata_next[3:0] = rx_fill;
      ifa_pkg::OFS_UPPER_ADDR: rdata_next[2:0] = upper_addr_reg;
      ifa_pkg::OFS_RX_THRESHOLD: rdata_next[3:0] = rx_threshold_reg;
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge rstn_core) begin
    if (!rstn_core) begin
      o_reg_rdata <= 32'h0000_0000;
    end else if (i_reg_rd) begin
      o_reg_rdata <= rdata_next;
    end
  end

  // ************************************************
  // Queues
  // ************************************************
  // flush request crosses as a level
  logic flush_l1_reg;
  logic flush_l2_reg;

  always_ff @(posedge i_link_clk or negedge rstn_link) begin
    if (!rstn_link) begin
      flush_l1_reg <= 1'b0;
      flush_l2_reg <= 1'b0;
    end else begin
      flush_l1_reg <= i_tx_queue_reset;
      flush_l2_reg <= flush_l1_reg;
    end
  end

  ifa_async_fifo #(.W(ifa_pkg::TX_ENTRY_W), .AW(AW)) u_tx_queue (
    .i_wclk(i_core_clk),
    .i_wrst_n(rstn_core),
    .i_wr(tx_wr),
    .i_wdata(i_reg_wdata[ifa_pkg::TX_ENTRY_W-1:0]),
    .o_full(tx_full),
    .o_wcount(tx_wcount),
    .o_whead(tx_whead),
    .i_rclk(i_link_clk),
    .i_rrst_n(rstn_link),
    .i_rd(i_link_tx_pop),
    .i_flush(flush_l2_reg),
    .o_empty(tx_empty_link),
    .o_rcount(),
    .o_rhead(tx_rhead)
  );

  // engine pushes only after the acknowledge bit
  ifa_async_fifo #(.W(ifa_pkg::DATA_W), .AW(AW)) u_rx_queue (
    .i_wclk(i_link_clk),
    .i_wrst_n(rstn_link),
    .i_wr(i_link_rx_push),
    .i_wdata(i_link_rx_data),
    .o_full(rx_full_link),
    .o_wcount(rx_wcount),
    .o_whead(),
    .i_rclk(i_core_clk),
    .i_rrst_n(rstn_core),
    .i_rd(rx_pop),
    .i_flush(1'b0),
    .o_empty(rx_empty),
    .o_rcount(rx_rcount),
    .o_rhead(rx_rhead)
  );

  assign o_rx_full = (rx_rcount == (AW+1)'(2 ** AW));

  // ************************************************
  // Link side: entries, mode edges, throttle
  // ************************************************
  // Quasi-static settings cross bit by bit; software changes them only when idle
  logic [2:0] master_slave_select_sync_reg;
  logic [3:0] thr_l1_reg;
  logic [3:0] thr_l2_reg;
  logic [6:0] own_l1_reg;
  logic [6:0] own_l2_reg;
  logic [2:0] upper_l1_reg;
  logic [2:0] upper_l2_reg;
  logic [3:0] rx_wfill;

  always_ff @(posedge i_link_clk or negedge rstn_link) begin
    if (!rstn_link) begin
      master_slave_select_sync_reg <= 3'h0;
      thr_l1_reg <= ifa_pkg::FILL_RESET;
      thr_l2_reg <= ifa_pkg::FILL_RESET;
      own_l1_reg <= ifa_pkg::OWN_RESET;
      own_l2_reg <= ifa_pkg::OWN_RESET;
      upper_l1_reg <= ifa_pkg::UPPER_RESET;
      upper_l2_reg <= ifa_pkg::UPPER_RESET;
      o_link_gen_start <= 1'b0;
      o_link_gen_stop <= 1'b0;
    end else begin
      master_slave_select_sync_reg <= {master_slave_select_sync_reg[1:0], i_master_slave_select};
      thr_l1_reg <= rx_threshold_reg;
      thr_l2_reg <= thr_l1_reg;
      own_l1_reg <= own_addr_reg;
      own_l2_reg <= own_l1_reg;
      upper_l1_reg <= upper_addr_reg;
      upper_l2_reg <= upper_l1_reg;
      // select edges ask for start or stop
      o_link_gen_start <= master_slave_select_sync_reg[1] && !master_slave_select_sync_reg[2];
      o_link_gen_stop <= !master_slave_select_sync_reg[1] && master_slave_select_sync_reg[2];
    end
  end

  // head entry offered to the engine
  assign o_link_tx_valid = !tx_empty_link && !flush_l2_reg;
  assign o_link_tx_data = tx_rhead[7:0];
  // start flag gives start, or repeat start when the synchronised select is already high
  assign o_link_tx_start = o_link_tx_valid && tx_rhead[ifa_pkg::TX_START_BIT]
    && !master_slave_select_sync_reg[2];
  assign o_link_tx_repeat_start = o_link_tx_valid && tx_rhead[ifa_pkg::TX_START_BIT]
    && master_slave_select_sync_reg[2];
  assign o_link_tx_stop = o_link_tx_valid && tx_rhead[ifa_pkg::TX_STOP_BIT];
  // data is a receive count here
  assign o_link_rx_count_valid = o_link_tx_stop && i_link_master_rx;

  // throttle only at equality, or when no room is left
  assign rx_wfill = (rx_wcount == '0) ? ifa_pkg::FILL_RESET : 4'(rx_wcount - ONE);
  assign o_link_throttle = rx_full_link || ((rx_wcount != '0) && (rx_wfill == thr_l2_reg));

  // ************************************************
  // Own-address match
  // ************************************************
  logic upper_hit_reg;
  logic first_ok;
  logic low_ok;

  // upper bits first, lower seven on the second byte
  assign first_ok = (i_link_addr_byte[7:4] == ifa_pkg::WIDE_PREFIX)
    && (i_link_addr_byte[3:1] == upper_l2_reg);
  assign low_ok = (i_link_addr_byte[7:1] == own_l2_reg);

  always_ff @(posedge i_link_clk or negedge rstn_link) begin
    if (!rstn_link) begin
      upper_hit_reg <= 1'b0;
      o_link_addr_ack <= 1'b0;
    end else begin
      o_link_addr_ack <= 1'b0;
      if (i_link_addr_valid) begin
        if (WIDE_ADDRESS_OPTION) begin
          if (!i_link_addr_second) begin
            upper_hit_reg <= first_ok;
          end else begin
            // acknowledge only on a full match
            o_link_addr_ack <= upper_hit_reg && low_ok;
            upper_hit_reg <= 1'b0;
          end
        end else begin
          // acknowledge only on a full match
          o_link_addr_ack <= low_ok;
        end
      end
    end
  end
endmodule // ifa_top

// File: include/ifa_pkg.sv
// Shared constants for the two-wire queue and own-address block.
// Assumes a simple register port with word byte addresses and one byte engine.
package ifa_pkg;
  localparam int unsigned REG_AW = 9;
  localparam logic [8:0] OFS_TX_KEYHOLE = 9'h108;
  localparam logic [8:0] OFS_RX_KEYHOLE = 9'h10c;
  localparam logic [8:0] OFS_OWN_ADDR = 9'h110;
  localparam logic [8:0] OFS_TX_FILL = 9'h114;
  localparam logic [8:0] OFS_RX_FILL = 9'h118;
  localparam logic [8:0] OFS_UPPER_ADDR = 9'h11c;
  localparam logic [8:0] OFS_RX_THRESHOLD = 9'h120;
  localparam int unsigned QUEUE_AW = 4;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned TX_ENTRY_W = 10;
  localparam int unsigned TX_START_BIT = 8;
  localparam int unsigned TX_STOP_BIT = 9;
  localparam int unsigned FILL_W = 4;
  localparam int unsigned OWN_MSB = 7;
  localparam int unsigned OWN_LSB = 1;
  localparam int unsigned UPPER_W = 3;
  localparam logic [6:0] OWN_RESET = 7'h00;
  localparam logic [2:0] UPPER_RESET = 3'h0;
  localparam logic [3:0] FILL_RESET = 4'h0;
  localparam logic [3:0] WIDE_PREFIX = 4'hf;
endpackage

// File: tb/ifa_checker.sv
// Port-level checks for the queue and own-address block.
// Assumes binding into ifa_top; the raw reset input disables every check.
`timescale 1ns/1ps
// ****************
// Checker
// ****************
module ifa_checker #(
  parameter bit WIDE_ADDRESS_OPTION = 1'b1
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_link_clk,
  input wire logic [8:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [31:0] o_reg_rdata,
  input wire logic i_tx_queue_reset,
  input wire logic o_tx_empty,
  input wire logic o_tx_full,
  input wire logic o_rx_empty,
  input wire logic o_rx_level_hit,
  input wire logic o_link_tx_start,
  input wire logic o_link_tx_repeat_start,
  input wire logic o_link_tx_stop,
  input wire logic o_link_rx_count_valid,
  input wire logic i_link_master_rx,
  input wire logic i_link_addr_valid,
  input wire logic i_link_addr_second,
  input wire logic o_link_addr_ack
);
  sequence rd_s(a);
    i_reg_rd && i_reg_addr == a;
  endsequence
  // Accepted write: not full and no flush in progress
  sequence tx_push_s;
    i_reg_wr && i_reg_addr == ifa_pkg::OFS_TX_KEYHOLE && !o_tx_full && !i_tx_queue_reset;
  endsequence

  tx_read_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    rd_s(ifa_pkg::OFS_TX_KEYHOLE) |=> o_reg_rdata[31:8] == 24'h0)
    else $error("flag bits visible on keyhole read");
  own_read_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    rd_s(ifa_pkg::OFS_OWN_ADDR) |=> o_reg_rdata[31:8] == 24'h0 && o_reg_rdata[0] == 1'b0)
    else $error("own address read outside bits 7 to 1");
  upper_read_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    rd_s(ifa_pkg::OFS_UPPER_ADDR) |=> o_reg_rdata[31:3] == 29'h0
      && (WIDE_ADDRESS_OPTION || o_reg_rdata == 32'h0))
    else $error("upper address read out of field");
  fill_read_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    rd_s(ifa_pkg::OFS_TX_FILL) |=> o_reg_rdata[31:4] == 28'h0)
    else $error("fill level read out of field");
  tx_push_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    tx_push_s |=> !o_tx_empty)
    else $error("empty flag high after accepted write");
  level_hit_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    o_rx_level_hit |-> !o_rx_empty)
    else $error("level hit with empty receive queue");
  addr_ack_a: assert property (@(posedge i_link_clk) disable iff (!i_resetn)
    o_link_addr_ack |-> $past(i_link_addr_valid && (i_link_addr_second || !WIDE_ADDRESS_OPTION)))
    else $error("address acknowledge without address byte");
  count_valid_a: assert property (@(posedge i_link_clk) disable iff (!i_resetn)
    o_link_rx_count_valid |-> o_link_tx_stop && i_link_master_rx)
    else $error("count marked without stop and receive");
  start_kind_a: assert property (@(posedge i_link_clk) disable iff (!i_resetn)
    !(o_link_tx_start && o_link_tx_repeat_start))
    else $error("start and repeat start together");
endmodule // ifa_checker

bind ifa_top ifa_checker #(.WIDE_ADDRESS_OPTION(WIDE_ADDRESS_OPTION)) chk (
  .i_core_clk, .i_resetn, .i_link_clk, .i_reg_addr, .i_reg_wr, .i_reg_rd, .o_reg_rdata,
  .i_tx_queue_reset, .o_tx_empty, .o_tx_full, .o_rx_empty, .o_rx_level_hit,
  .o_link_tx_start, .o_link_tx_repeat_start, .o_link_tx_stop, .o_link_rx_count_valid,
  .i_link_master_rx, .i_link_addr_valid, .i_link_addr_second, .o_link_addr_ack
);

// File: tb/ifa_engine_model.sv
// Byte engine stand-in on the link clock side of the queue block.
// Assumes the bench calls one task at a time.
`timescale 1ns/1ps
// ****************
// Engine model
// ****************
module ifa_engine_model (
  input wire logic i_link_clk,
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  input wire logic i_tx_start,
  input wire logic i_tx_repeat_start,
  input wire logic i_tx_stop,
  input wire logic i_rx_count_valid,
  input wire logic i_throttle,
  input wire logic i_gen_start,
  input wire logic i_gen_stop,
  input wire logic i_addr_ack,
  output logic o_master_rx,
  output logic o_tx_pop,
  output logic o_rx_push,
  output logic [7:0] o_rx_data,
  output logic o_addr_valid,
  output logic o_addr_second,
  output logic [7:0] o_addr_byte
);
  int n_start = 0;
  int n_stop = 0;
  initial begin
    o_master_rx = 1'b0;
    o_tx_pop = 1'b0;
    o_rx_push = 1'b0;
    o_rx_data = 8'h5a;
    o_addr_valid = 1'b0;
    o_addr_second = 1'b0;
    o_addr_byte = 8'ha5;
  end
  always @(posedge i_link_clk) begin
    if (i_gen_start) n_start++;
    if (i_gen_stop) n_stop++;
  end
  task automatic pop(input logic mrx, output logic [12:0] e);
    int n;
    n = 0;
    o_master_rx = mrx;
    @(posedge i_link_clk);
    while (!i_tx_valid && n < 64) begin
      @(posedge i_link_clk);
      n++;
    end
    #1;
    e = i_tx_valid ? {i_rx_count_valid, i_tx_stop, i_tx_repeat_start, i_tx_start, i_tx_data} : 'x;
    o_tx_pop = 1'b1;
    @(posedge i_link_clk);
    #1;
    o_tx_pop = 1'b0;
  endtask
  // push after ack, stall on throttle
  task automatic push(input logic [7:0] b);
    int n;
    n = 0;
    @(posedge i_link_clk);
    while (i_throttle && n < 64) begin
      @(posedge i_link_clk);
      n++;
    end
    #1;
    o_rx_data = b;
    o_rx_push = 1'b1;
    @(posedge i_link_clk);
    #1;
    o_rx_push = 1'b0;
    o_rx_data = ~b;
  endtask
  task automatic addr(input logic [7:0] hi, input logic [7:0] lo, output logic a);
    @(posedge i_link_clk);
    #1;
    o_addr_valid = 1'b1;
    o_addr_byte = hi;
    @(posedge i_link_clk);
    #1;
    o_addr_second = 1'b1;
    o_addr_byte = lo;
    @(posedge i_link_clk);
    #1;
    o_addr_valid = 1'b0;
    o_addr_second = 1'b0;
    o_addr_byte = ~lo;
    a = i_addr_ack;
  endtask
endmodule // ifa_engine_model

// File: tb/ifa_tb_top.sv
// Self-checking bench for the queue and own-address block.
// Assumes the engine model on the link side and the bound checker.
`timescale 1ns/1ps
// ****************
// Bench top
// ****************
module ifa_tb_top;
  logic i_core_clk, i_link_clk, i_resetn, i_reg_wr, i_reg_rd, ack;
  logic i_master_slave_select, i_tx_queue_reset, i_link_master_rx, i_link_tx_pop;
  logic i_link_rx_push, i_link_addr_valid, i_link_addr_second;
  logic [8:0] i_reg_addr;
  logic [31:0] i_reg_wdata, o_reg_rdata, rd;
  logic [7:0] i_link_rx_data, i_link_addr_byte, o_link_tx_data;
  logic o_tx_empty, o_tx_full, o_rx_empty, o_rx_full, o_rx_level_hit, o_link_tx_valid;
  logic o_link_tx_start, o_link_tx_repeat_start, o_link_tx_stop, o_link_rx_count_valid;
  logic o_link_throttle, o_link_gen_start, o_link_gen_stop, o_link_addr_ack;
  logic [12:0] ent;
  logic [7:0] hi_tab [5] = '{8'hfa, 8'hf8, 8'hfa, 8'h7a, 8'hfb};
  logic [7:0] lo_tab [5] = '{8'h54, 8'h54, 8'h56, 8'h54, 8'h55};
  int num_errors = 0;
  int checks_done = 0;

  initial begin
    i_core_clk = 1'b0;
    forever #20 i_core_clk = ~i_core_clk;
  end
  // Offset keeps link edges apart from core edges
  initial begin
    i_link_clk = 1'b0;
    #7;
    forever #32 i_link_clk = ~i_link_clk;
  end

  ifa_top dut (
    .i_core_clk, .i_resetn, .i_link_clk, .i_reg_addr, .i_reg_wr, .i_reg_rd, .i_reg_wdata,
    .o_reg_rdata, .i_master_slave_select, .i_tx_queue_reset, .o_tx_empty, .o_tx_full,
    .o_rx_empty, .o_rx_full, .o_rx_level_hit, .o_link_tx_valid, .o_link_tx_data,
    .o_link_tx_start, .o_link_tx_repeat_start, .o_link_tx_stop, .o_link_rx_count_valid,
    .i_link_master_rx, .i_link_tx_pop, .i_link_rx_push, .i_link_rx_data, .o_link_throttle,
    .o_link_gen_start, .o_link_gen_stop, .i_link_addr_valid, .i_link_addr_second,
    .i_link_addr_byte, .o_link_addr_ack
  );
  ifa_engine_model eng (
    .i_link_clk, .i_tx_valid(o_link_tx_valid), .i_tx_data(o_link_tx_data),
    .i_tx_start(o_link_tx_start), .i_tx_repeat_start(o_link_tx_repeat_start),
    .i_tx_stop(o_link_tx_stop), .i_rx_count_valid(o_link_rx_count_valid),
    .i_throttle(o_link_throttle), .i_gen_start(o_link_gen_start),
    .i_gen_stop(o_link_gen_stop), .i_addr_ack(o_link_addr_ack),
    .o_master_rx(i_link_master_rx), .o_tx_pop(i_link_tx_pop), .o_rx_push(i_link_rx_push),
    .o_rx_data(i_link_rx_data), .o_addr_valid(i_link_addr_valid),
    .o_addr_second(i_link_addr_second), .o_addr_byte(i_link_addr_byte)
  );

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: flag %b want %b", $time, got, exp);
    end
  endtask
  // Returns 1 ns after an edge so drives stay off the edge
  task automatic cw(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask
  task automatic reg_wr(input logic [8:0] a, input logic [31:0] d);
    cw(1);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1'b1;
    cw(1);
    i_reg_wr = 1'b0;
  endtask
  task automatic check_rd(input logic [8:0] a, input logic [31:0] e);
    cw(1);
    i_reg_addr = a;
    i_reg_rd = 1'b1;
    cw(1);
    i_reg_rd = 1'b0;
    cmp_word(o_reg_rdata, e);
  endtask
  task automatic flush_tx();
    cw(1);
    i_tx_queue_reset = 1'b1;
    reg_wr(ifa_pkg::OFS_TX_KEYHOLE, 32'h0aa);
    cw(40);
    i_tx_queue_reset = 1'b0;
    cw(20);
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #300us;
    num_errors++;
    $display("ERROR %0t: watchdog expired", $time);
    end_of_test();
  end

  initial begin
    {i_resetn, i_reg_wr, i_reg_rd, i_master_slave_select, i_tx_queue_reset} = 5'h0;
    i_reg_addr = 9'h0;
    i_reg_wdata = 32'h0;
    cw(8);
    i_resetn = 1'b1;
    cw(8);
    cmp_bit(o_tx_empty, 1'b1);
    check_rd(ifa_pkg::OFS_TX_FILL, 32'h0);
    check_rd(ifa_pkg::OFS_OWN_ADDR, 32'h0);
    check_rd(ifa_pkg::OFS_UPPER_ADDR, 32'h0);
    check_rd(9'h124, 32'h0);
    reg_wr(ifa_pkg::OFS_OWN_ADDR, 32'hffff_ffff);
    check_rd(ifa_pkg::OFS_OWN_ADDR, 32'hfe);
    reg_wr(ifa_pkg::OFS_UPPER_ADDR, 32'hffff_ffff);
    check_rd(ifa_pkg::OFS_UPPER_ADDR, 32'h7);
    reg_wr(ifa_pkg::OFS_OWN_ADDR, 32'h54);
    reg_wr(ifa_pkg::OFS_UPPER_ADDR, 32'h5);
    cw(10);
    for (int i = 0; i < 5; i++) begin
      eng.addr(hi_tab[i], lo_tab[i], ack);
      cmp_bit(ack, i == 0 || i == 4);
    end
    flush_tx();
    for (int i = 0; i < 17; i++) begin
      reg_wr(ifa_pkg::OFS_TX_KEYHOLE, {22'h0, i == 15, i == 0, 8'(8'h10 + i)});
      if (i == 0) check_rd(ifa_pkg::OFS_TX_FILL, 32'h0);
    end
    check_rd(ifa_pkg::OFS_TX_FILL, 32'hf);
    cmp_bit(o_tx_full, 1'b1);
    check_rd(ifa_pkg::OFS_TX_KEYHOLE, 32'h10);
    check_rd(ifa_pkg::OFS_TX_KEYHOLE, 32'h10);
    for (int i = 0; i < 16; i++) begin
      eng.pop(i == 15, ent);
      cmp_word({19'h0, ent}, {20'h0, i == 15, i == 15, 1'b0, i == 0, 8'(8'h10 + i)});
    end
    cw(20);
    cmp_bit(o_link_tx_valid, 1'b0);
    cmp_bit(o_tx_empty, 1'b1);
    i_master_slave_select = 1'b1;
    cw(20);
    cmp_word(32'(eng.n_start), 32'h1);
    reg_wr(ifa_pkg::OFS_TX_KEYHOLE, 32'h3ab);
    eng.pop(1'b0, ent);
    cmp_word({19'h0, ent}, {19'h0, 5'b00110, 8'hab});
    cw(1);
    i_master_slave_select = 1'b0;
    cw(20);
    cmp_word(32'(eng.n_stop), 32'h1);
    for (int i = 0; i < 3; i++) reg_wr(ifa_pkg::OFS_TX_KEYHOLE, 32'h33);
    flush_tx();
    cmp_bit(o_tx_empty, 1'b1);
    cmp_bit(o_link_tx_valid, 1'b0);
    reg_wr(ifa_pkg::OFS_RX_THRESHOLD, 32'h2);
    cw(10);
    for (int i = 0; i < 3; i++) begin
      eng.push(8'(8'h60 + i));
      cw(10);
      cmp_bit(o_rx_level_hit, i == 2);
      cmp_bit(o_link_throttle, i == 2);
    end
    check_rd(ifa_pkg::OFS_RX_FILL, 32'h2);
    reg_wr(ifa_pkg::OFS_RX_KEYHOLE, 32'hff);
    for (int i = 0; i < 3; i++) begin
      check_rd(ifa_pkg::OFS_RX_KEYHOLE, 32'(8'h60 + i));
      cw(10);
      cmp_bit(o_rx_level_hit, 1'b0);
    end
    reg_wr(ifa_pkg::OFS_RX_THRESHOLD, 32'hf);
    cw(4);
    for (int i = 0; i < 16; i++) eng.push(8'(8'h70 + i));
    cw(10);
    cmp_bit(o_rx_full, 1'b1);
    cmp_bit(o_link_throttle, 1'b1);
    for (int i = 0; i < 16; i++) check_rd(ifa_pkg::OFS_RX_KEYHOLE, 32'(8'h70 + i));
    cmp_bit(o_rx_full, 1'b0);
    cmp_bit(o_rx_empty, 1'b1);
    reg_wr(ifa_pkg::OFS_TX_KEYHOLE, 32'h0c3);
    cw(20);
    i_resetn = 1'b0;
    cw(8);
    i_resetn = 1'b1;
    cw(8);
    check_rd(ifa_pkg::OFS_TX_KEYHOLE, 32'hc3);
    cmp_word({24'h0, o_link_tx_data}, 32'hc3);
    cmp_bit(o_tx_empty, 1'b1);
    end_of_test();
  end
endmodule // ifa_tb_top
